//--- rtl/tpcs_map.svh
// Register offsets, field positions, reset values and codes of the timer prescaler block.
`ifndef TPCS_MAP_SVH
`define TPCS_MAP_SVH

`define TPCS_CTRL_OFF 12'h000
`define TPCS_CS0_OFF 12'h004
`define TPCS_CS1_OFF 12'h008
`define TPCS_STAT_OFF 12'h00c

`define TPCS_HOLD_BIT 7
`define TPCS_PSR_BIT 0
`define TPCS_CTRL_RST 8'h00
`define TPCS_CS_RST 3'h0

`define TPCS_CS_STOP 3'h0
`define TPCS_CS_SYS 3'h1
`define TPCS_CS_DIV8 3'h2
`define TPCS_CS_DIV64 3'h3
`define TPCS_CS_DIV256 3'h4
`define TPCS_CS_DIV1024 3'h5
`define TPCS_CS_EXT_FALL 3'h6
`define TPCS_CS_EXT_RISE 3'h7

`define TPCS_PRE_W 10
`define TPCS_TAP8_W 3
`define TPCS_TAP64_W 6
`define TPCS_TAP256_W 8
`define TPCS_TAP1024_W 10

`endif

//--- rtl/tpcs_pkg.sv
// Types shared by the timer prescaler and clock select logic.
package tpcs_pkg;
    typedef logic [2:0] tpcs_code_t;
    typedef enum logic [1:0] {
        TPCS_BUS_IDLE = 2'b01,
        TPCS_BUS_ACK = 2'b10
    } tpcs_bus_t;
endpackage

//--- rtl/tpcs_ext_if.sv
// Interface between the clock select logic and one count pin edge detector.
`timescale 1ns/100ps
interface tpcs_ext_if;
    logic [2:0] code;
    logic pulse;
    modport ctrl (output code, input pulse);
    modport edge_det (input code, output pulse);
endinterface

//--- rtl/tpcs_pin_edge.sv
// Count pin synchroniser and edge detector for one timer.
`timescale 1ns/100ps
module tpcs_pin_edge
    import tpcs_pkg::*;
(
    input wire logic pclk, // System clock.
    input wire logic presetn, // Asynchronous reset, active low.
    input wire logic pin, // Raw external count pin.
    tpcs_ext_if.edge_det ext // Select code in, count pulse out.
);
`include "tpcs_map.svh"

    logic lat_q, lat_d;
    logic sync_q, sync_d;
    logic prev_q, prev_d;

    // The negative-edge stage stands for the latch that is open while pclk is high.
    always_comb begin
        lat_d = pin;
        sync_d = lat_q;
        prev_d = sync_q;
    end

    always_ff @(negedge pclk or negedge presetn) begin
        if (!presetn) begin
            lat_q <= 1'b0;
        end else begin
            lat_q <= lat_d;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sync_q <= 1'b0;
            prev_q <= 1'b0;
        end else begin
            sync_q <= sync_d;
            prev_q <= prev_d;
        end
    end

    // One pulse per detected edge of the chosen polarity; never through the divider.
    always_comb begin
        case (ext.code)
            `TPCS_CS_EXT_RISE: ext.pulse = sync_q & ~prev_q;
            `TPCS_CS_EXT_FALL: ext.pulse = ~sync_q & prev_q;
            default: ext.pulse = 1'b0;
        endcase
    end
endmodule

//--- rtl/tpcs_top.sv
// Shared prescaler, per-timer clock select and APB control register file.
//
// The implementer's own choices: the placing of the registers and the APB register port.
`timescale 1ns/100ps
//
// Overview of operation
// - One shared prescaler, independent selects per timer.
// - Code 1 ticks every system clock.
// - Taps divide by 8, 64, 256, 1024.
// - Prescaler free running, untouched by selects.
// - First prescaled tick after 1 to N cycles.
// - Count pin sampled every system clock.
// - Latch open on high, then rising-edge registers.
// - Pulse per rising edge (7) or falling (6).
// - Pin edge to tick 1.5 to 2.5 cycles.
// - Pin pulses bypass the prescaler.
// - Hold mode keeps prescaler reset bit asserted.
// - Clearing hold mode loads reset bit from the write data.
// - Reset bit holds prescaler; self clears otherwise.
// - Codes 110 fall, 111 rise, 101 divide 1024.
// - Pin counts even when driven as output.
module tpcs_top
    import tpcs_pkg::*;
#(
    parameter int NUM_TIMERS = 2
) (
    input wire logic pclk, // System clock, 200 MHz.
    input wire logic presetn, // Asynchronous reset, active low.
    input wire logic psel, // APB select.
    input wire logic penable, // APB enable.
    input wire logic pwrite, // APB direction, high for write.
    input wire logic [11:0] paddr, // APB byte address.
    input wire logic [31:0] pwdata, // APB write data.
    input wire logic [3:0] pstrb, // APB byte strobes.
    output logic [31:0] prdata, // APB read data.
    output logic pready, // APB ready.
    output logic pslverr, // APB error for unmapped addresses.
    input wire logic [NUM_TIMERS-1:0] ext_count_pin, // External count pins.
    output logic [NUM_TIMERS-1:0] counter_tick, // One-cycle count enable per timer.
    output logic prescaler_reset_bit // Prescaler held in reset.
);
`include "tpcs_map.svh"

    ////////////////////////////////////////////////////////////////////////////
    // APB slave: one wait state, every access answered on the second access cycle.

    tpcs_bus_t bus_q, bus_d;
    logic [31:0] prdata_q, prdata_d;
    logic pslverr_q, pslverr_d;
    logic sync_hold_mode_q, sync_hold_mode_d;
    logic psr_q, psr_d;
    tpcs_code_t clock_source_code_q [NUM_TIMERS];
    tpcs_code_t clock_source_code_d [NUM_TIMERS];
    logic [`TPCS_PRE_W-1:0] pre_q, pre_d;
    logic [NUM_TIMERS-1:0] tick_q, tick_d;
    logic [NUM_TIMERS-1:0] ext_pulse;
    logic wr_en;
    logic mapped;
    logic [31:0] rd_val;

    always_comb begin
        mapped = 1'b1;
        rd_val = 32'h0000_0000;
        case (paddr)
            `TPCS_CTRL_OFF: begin
                rd_val[`TPCS_HOLD_BIT] = sync_hold_mode_q;
                rd_val[`TPCS_PSR_BIT] = psr_q;
            end
            `TPCS_CS0_OFF: rd_val[2:0] = clock_source_code_q[0];
            `TPCS_CS1_OFF: rd_val[2:0] = clock_source_code_q[1];
            `TPCS_STAT_OFF: begin
                rd_val[`TPCS_PRE_W-1:0] = pre_q;
                rd_val[16 +: NUM_TIMERS] = tick_q;
            end
            default: mapped = 1'b0;
        endcase
    end

    assign wr_en = (bus_q == TPCS_BUS_ACK) && psel && penable && pwrite && mapped && pstrb[0];

    always_comb begin
        bus_d = TPCS_BUS_IDLE;
        prdata_d = 32'h0000_0000;
        pslverr_d = 1'b0;
        case (bus_q)
            TPCS_BUS_IDLE: begin
                if (psel && penable) begin
                    bus_d = TPCS_BUS_ACK;
                    prdata_d = pwrite ? 32'h0000_0000 : rd_val;
                    pslverr_d = ~mapped;
                end
            end
            TPCS_BUS_ACK: bus_d = TPCS_BUS_IDLE;
            default: bus_d = TPCS_BUS_IDLE;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////
    // Control register and clock select codes.

    always_comb begin
        sync_hold_mode_d = sync_hold_mode_q;
        psr_d = psr_q;
        for (int i = 0; i < NUM_TIMERS; i++) begin
            clock_source_code_d[i] = clock_source_code_q[i];
        end
        // Without hold mode the reset bit lasts a single cycle.
        if (!sync_hold_mode_q) begin
            psr_d = 1'b0;
        end
        if (wr_en && paddr == `TPCS_CTRL_OFF) begin
            sync_hold_mode_d = pwdata[`TPCS_HOLD_BIT];
            if (pwdata[`TPCS_HOLD_BIT]) begin
                psr_d = pwdata[`TPCS_PSR_BIT];
            end else begin
                psr_d = pwdata[`TPCS_PSR_BIT];
            end
        end
        if (wr_en && paddr == `TPCS_CS0_OFF) begin
            clock_source_code_d[0] = pwdata[2:0];
        end
        if (wr_en && paddr == `TPCS_CS1_OFF) begin
            clock_source_code_d[1] = pwdata[2:0];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            bus_q <= TPCS_BUS_IDLE;
            prdata_q <= 32'h0000_0000;
            pslverr_q <= 1'b0;
            sync_hold_mode_q <= 1'b0;
            psr_q <= 1'b0;
            for (int i = 0; i < NUM_TIMERS; i++) begin
                clock_source_code_q[i] <= `TPCS_CS_RST;
            end
        end else begin
            bus_q <= bus_d;
            prdata_q <= prdata_d;
            pslverr_q <= pslverr_d;
            sync_hold_mode_q <= sync_hold_mode_d;
            psr_q <= psr_d;
            for (int i = 0; i < NUM_TIMERS; i++) begin
                clock_source_code_q[i] <= clock_source_code_d[i];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Shared prescaler: only the reset bit can stop or clear it.

    always_comb begin
        if (psr_q) begin
            pre_d = '0;
        end else begin
            pre_d = pre_q + `TPCS_PRE_W'(1);
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Per-timer source selection. The count pin is always sampled, whatever
    // its direction, so software can drive it to count.

    genvar g;
    generate
        for (g = 0; g < NUM_TIMERS; g++) begin : g_tmr
            tpcs_ext_if ext ();
            assign ext.code = clock_source_code_q[g];
            assign ext_pulse[g] = ext.pulse;
            tpcs_pin_edge u_edge (
                .pclk(pclk),
                .presetn(presetn),
                .pin(ext_count_pin[g]),
                .ext(ext.edge_det)
            );
        end
    endgenerate

    always_comb begin
        for (int i = 0; i < NUM_TIMERS; i++) begin
            // A tap fires when the low bits of the shared counter are all ones,
            // so the first tick lands anywhere within one divider period.
            case (clock_source_code_q[i])
                `TPCS_CS_STOP: tick_d[i] = 1'b0;
                `TPCS_CS_SYS: tick_d[i] = 1'b1;
                `TPCS_CS_DIV8: tick_d[i] = ~psr_q & (&pre_q[`TPCS_TAP8_W-1:0]);
                `TPCS_CS_DIV64: tick_d[i] = ~psr_q & (&pre_q[`TPCS_TAP64_W-1:0]);
                `TPCS_CS_DIV256: tick_d[i] = ~psr_q & (&pre_q[`TPCS_TAP256_W-1:0]);
                `TPCS_CS_DIV1024: tick_d[i] = ~psr_q & (&pre_q);
                default: tick_d[i] = ext_pulse[i];
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pre_q <= '0;
            tick_q <= '0;
        end else begin
            pre_q <= pre_d;
            tick_q <= tick_d;
        end
    end

    assign prdata = prdata_q;
    assign pready = (bus_q == TPCS_BUS_ACK);
    assign pslverr = pslverr_q;
    assign counter_tick = tick_q;
    assign prescaler_reset_bit = psr_q;
endmodule

//--- tb/tpcs_tb_assertions.sv
// Port checks for the timer prescaler block.
`timescale 1ns/100ps
`include "tpcs_map.svh"
module tpcs_tb_assertions #(
    parameter int NUM_TIMERS = 2
) (
    input wire logic pclk, // Clock.
    input wire logic presetn, // Reset.
    input wire logic psel, // Select.
    input wire logic penable, // Enable.
    input wire logic pwrite, // Direction.
    input wire logic [11:0] paddr, // Address.
    input wire logic [31:0] pwdata, // Write data.
    input wire logic [3:0] pstrb, // Strobes.
    input wire logic [31:0] prdata, // Read data.
    input wire logic pready, // Ready.
    input wire logic pslverr, // Error.
    input wire logic [NUM_TIMERS-1:0] ext_count_pin, // Pins.
    input wire logic [NUM_TIMERS-1:0] counter_tick, // Ticks.
    input wire logic prescaler_reset_bit // Reset bit.
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    logic wr_ctl;
    logic wr_cs0;
    logic hold_q;
    logic [2:0] c0_q;
    assign wr_ctl = psel && penable && pready && pwrite && pstrb[0] && paddr == `TPCS_CTRL_OFF;
    assign wr_cs0 = psel && penable && pready && pwrite && pstrb[0] && paddr == `TPCS_CS0_OFF;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            hold_q <= 1'b0;
            c0_q <= 3'h0;
        end else begin
            hold_q <= wr_ctl ? pwdata[`TPCS_HOLD_BIT] : hold_q;
            c0_q <= wr_cs0 ? pwdata[2:0] : c0_q;
        end
    end
    ////////////////////////////////////////////////////////////////////////
    psr_clear_a: assert property (!hold_q && prescaler_reset_bit |=> !prescaler_reset_bit)
        else $error("reset bit stuck");
    psr_hold_a: assert property (hold_q && prescaler_reset_bit && !wr_ctl |=> prescaler_reset_bit)
        else $error("reset bit lost in hold");
    hold_clear_a: assert property (wr_ctl && !pwdata[7] && !pwdata[0] |-> ##2 !prescaler_reset_bit)
        else $error("reset bit not cleared");
    sys_tick_a: assert property (c0_q == 3'h1 ##1 c0_q == 3'h1 |-> counter_tick[0])
        else $error("no system tick");
    stop_tick_a: assert property (c0_q == 3'h0 ##1 c0_q == 3'h0 |-> !counter_tick[0])
        else $error("tick while stopped");
    div8_gap_a: assert property (c0_q == 3'h2 && counter_tick[0] |=> (!counter_tick[0] || c0_q != 3'h2) [*7])
        else $error("divide by 8 gap");
    ext_rise_a: assert property (c0_q == 3'h7 && $rose(ext_count_pin[0]) |-> ##[1:3] counter_tick[0])
        else $error("rising edge not counted");
    ext_fall_a: assert property (c0_q == 3'h6 && $fell(ext_count_pin[0]) |-> ##[1:3] counter_tick[0])
        else $error("falling edge not counted");
    ext_single_a: assert property (c0_q[2:1] == 2'b11 && counter_tick[0] |=> !counter_tick[0])
        else $error("double pulse");
    cover property (c0_q == 3'h7 && counter_tick[0]);
    cover property (hold_q && prescaler_reset_bit);
    cover property (pslverr && pready);
endmodule
bind tpcs_top tpcs_tb_assertions #(.NUM_TIMERS(NUM_TIMERS)) chk_inst (.pclk, .presetn, .psel,
    .penable, .pwrite, .paddr, .pwdata, .pstrb, .prdata, .pready, .pslverr, .ext_count_pin,
    .counter_tick, .prescaler_reset_bit);

//--- tb/tpcs_pin_src.sv
// Behavioural external clock source for the count pins.
`timescale 1ns/100ps
module tpcs_pin_src (
    input wire logic run, // Toggle the pin while high.
    input wire logic [31:0] half_ns, // Half period, above one system clock.
    output logic pin // Count pin level.
);
    // The odd offset keeps pin edges away from system clock edges.
    initial begin
        pin = 1'b0;
        #0.3;
        forever begin
            #(half_ns);
            if (run)
                pin = ~pin;
        end
    end
endmodule

//--- tb/tb_top.sv
// Self-checking bench for the timer prescaler block.
`timescale 1ns/100ps
`include "tpcs_map.svh"
`define CHK(g, e, m) begin total_checks++; if ((g) !== (e)) begin n_fail++; \
    $display("mismatch %0t %s", $time, m); end end
module tb_top;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, run = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic [3:0] pstrb = 4'hf;
    logic pready, pslverr, pin, psr, err;
    logic [1:0] tick;
    int half_ns = 8;
    int n_fail = 0, total_checks = 0, tk0, tk1, rise_n, fall_n, c1, k;
    int divs[6] = '{0, 1, 8, 64, 256, 1024};
    always #2.5 pclk = ~pclk;
    always @(posedge pin) rise_n++;
    always @(negedge pin) fall_n++;
    tpcs_top tpcs_top_inst (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb,
        .prdata, .pready, .pslverr, .ext_count_pin({pin, pin}), .counter_tick(tick),
        .prescaler_reset_bit(psr));
    tpcs_pin_src tpcs_pin_src_inst (.run, .half_ns, .pin);
    ////////////////////////////////////////////////////////////////////////
    function automatic int expt(int c);
        return divs[c] == 0 ? 0 : 1024 / divs[c];
    endfunction
    task automatic summarize();
        if (n_fail == 0 && total_checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        k = 0;
        do begin
            @(posedge pclk);
            k++;
        end while (pready !== 1'b1 && k < 50);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (pready !== 1'b1) begin
            n_fail++;
            summarize();
        end
    endtask
    // Counts ticks over whole prescaler periods, so the phase does not matter.
    task automatic window(input int w);
        tk0 = 0;
        tk1 = 0;
        repeat (w) begin
            @(negedge pclk);
            tk0 += int'(tick[0] === 1'b1);
            tk1 += int'(tick[1] === 1'b1);
        end
    endtask
    ////////////////////////////////////////////////////////////////////////
    initial begin
        void'($urandom(43378));
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        for (int i = 0; i < 3; i++) begin
            apb(1'b0, 12'(4 * i), 32'h0);
            `CHK(rd, 32'h0, "reset value")
        end
        apb(1'b1, 12'h010, $urandom());
        `CHK(err, 1'b1, "unmapped write")
        apb(1'b0, 12'h010, 32'h0);
        `CHK({err, rd}, {1'b1, 32'h0}, "unmapped read")
        for (int i = 0; i < 6; i++) begin
            c1 = $urandom % 6;
            apb(1'b1, `TPCS_CS0_OFF, i);
            apb(1'b1, `TPCS_CS1_OFF, c1);
            apb(1'b0, `TPCS_CS0_OFF, 32'h0);
            `CHK(rd, 32'(i), "code readback")
            window(1024);
            `CHK(tk0, expt(i), "tick count 0")
            `CHK(tk1, expt(c1), "tick count 1")
        end
        apb(1'b1, `TPCS_CS0_OFF, 32'h2);
        apb(1'b1, `TPCS_CS1_OFF, 32'h3);
        apb(1'b1, `TPCS_CTRL_OFF, 32'h81);
        // A tick launched in the write cycle itself is still legal; skip it.
        @(posedge pclk);
        window(64);
        `CHK({psr, tk0 + tk1}, {1'b1, 32'h0}, "hold halts")
        apb(1'b0, `TPCS_CTRL_OFF, 32'h0);
        `CHK(rd, 32'h81, "hold readback")
        apb(1'b1, `TPCS_CTRL_OFF, 32'h0);
        apb(1'b0, `TPCS_CTRL_OFF, 32'h0);
        `CHK(rd, 32'h0, "hold release")
        window(1024);
        `CHK({tk0, tk1}, {expt(2), expt(3)}, "resume")
        apb(1'b1, `TPCS_CTRL_OFF, 32'h1);
        apb(1'b0, `TPCS_CTRL_OFF, 32'h0);
        `CHK(rd, 32'h0, "self clear")
        apb(1'b1, `TPCS_CS0_OFF, 32'h7);
        apb(1'b1, `TPCS_CS1_OFF, 32'h6);
        half_ns = 7 + $urandom % 8;
        rise_n = 0;
        fall_n = 0;
        run = 1'b1;
        fork
            begin
                repeat (380) @(negedge pclk);
                run = 1'b0;
            end
            window(400);
        join
        `CHK(tk0, rise_n, "rising count")
        `CHK(tk1, fall_n, "falling count")
        summarize();
    end
endmodule
